// >>> src/adcc_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH
`define ADCC_IDX_TAP6 12'h453
`define ADCC_IDX_TAP7 12'h455
`define ADCC_IDX_TAP8 12'h457
`define ADCC_IDX_TAP9 12'h459
`define ADCC_IDX_CTRL 12'h500
`define ADCC_IDX_LINK 12'h501
`define ADCC_IDX_CAL 12'h502
`define ADCC_IDX_STAT 12'h503
`define ADCC_COEF_W 12
`define ADCC_COEF_RST 12'h000
`define ADCC_CTRL_RESET_BIT 0
`define ADCC_CTRL_LINK_RUN_BIT 1
`define ADCC_CTRL_CAL_RUN_BIT 2
`define ADCC_CTRL_OVR_BIT 3
`define ADCC_CTRL_KICK_BIT 4
`define ADCC_CTRL_SYNCSRC_BIT 5
`define ADCC_CAL_BG_BIT 0
`define ADCC_CAL_OFS_BIT 1
`define ADCC_RESET_HOLD_NS 1000
`define ADCC_CLK_PERIOD_NS 5
`define ADCC_RESET_CYCLES \
  ((`ADCC_RESET_HOLD_NS + `ADCC_CLK_PERIOD_NS - 1) / `ADCC_CLK_PERIOD_NS)
`endif

// >>> src/adcc_pkg.sv
// Types shared by the configuration block
package adcc_pkg;
  typedef struct packed {
    logic link_run;
    logic cal_run;
    logic overrange_detect_on;
    logic sync_from_ts;
    logic cal_background;
    logic cal_offset;
    logic [4:0] link_format_select;
    logic [4:0] multiframe_length_minus_one;
  } adcc_cfg_t;
  typedef struct packed {
    logic signed [11:0] tap6;
    logic signed [11:0] tap7;
    logic signed [11:0] tap8;
    logic signed [11:0] tap9;
  } adcc_taps_t;
endpackage

// >>> src/adcc_sync2.sv
// Two-flop synchroniser for a pin level
`timescale 1ns/1ps
module adcc_sync2 (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic din,
  output logic dout
);
  logic meta;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// >>> src/adcc_link_fsm.sv
// Serial-link phase state machine driven by the receiver's sync request
`timescale 1ns/1ps
module adcc_link_fsm (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic sync_req,
  output logic [1:0] phase
);
  typedef enum {ST_STOP, ST_CGS, ST_ILAS, ST_DATA} adcc_link_st_t;
  adcc_link_st_t st;
  // Receiver holds sync low to request alignment, high to release
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      st <= ST_STOP;
    end else begin
      case (st)
        ST_STOP: st <= ST_CGS;
        ST_CGS: if (sync_req) st <= ST_ILAS;
        ST_ILAS: st <= sync_req ? ST_DATA : ST_CGS;
        ST_DATA: if (!sync_req) st <= ST_CGS;
        default: st <= ST_STOP;
      endcase
    end
  end
  always_comb begin
    case (st)
      ST_STOP: phase = 2'h0;
      ST_CGS: phase = 2'h1;
      ST_ILAS: phase = 2'h2;
      default: phase = 2'h3;
    endcase
  end
endmodule

// >>> src/adcc_top.sv
// Startup configuration and channel B equalizer taps over AXI4-Lite
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "adcc_params.svh"
// Functional notes
// - Writing one to reset trigger resets; host waits 1 us after.
// - Link run zero holds the link state machine stopped.
// - Calibration run zero holds the calibration state machine stopped.
// - Sync source select picks single-ended or timestamp pair input.
// - Foreground/background and offset calibration are selectable.
// - Calibration run one enables the calibration state machine.
// - Overrange detect enable bit exists, set before link restart.
// - Link run one restarts the link state machine.
// - Link phases follow the receiver's sync signal.
// - Calibration starts on a zero-to-one edge of the kick bit; here only with calibration run already one and kept one.
// - Tap registers: signed 12 bits, reset zero, upper four reserved.
// - Taps six to nine in ascending address order.
// - Nine-tap equalizer; centre tap 18 bits, outer taps 12 bits.
module adcc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic single_ended_sync_input,
  input wire logic timestamp_sync_input,
  input wire logic cal_done,
  output adcc_pkg::adcc_cfg_t cfg,
  output adcc_pkg::adcc_taps_t taps,
  output logic cal_start,
  output logic [1:0] link_phase,
  output logic soft_reset_active
);
  ////////////////////////////////////////////////////////////////////////
  logic have_aw, have_w;
  logic [15:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [11:0] reset_cnt;
  logic soft_rst;
  logic kick;
  logic cal_busy;
  logic sync_se, sync_ts, sync_sel;
  logic [1:0] phase;

  // Byte address is four times the register index
  function automatic logic [11:0] reg_idx(input logic [15:0] a);
    reg_idx = a[13:2];
  endfunction

  // Only the low lane pair carries data; the reserved nibble is dropped,
  // so a tap never holds more than its twelve coefficient bits
  function automatic logic [11:0] tap_merge(input logic [11:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
    logic [15:0] m;
    m = {s[1] ? d[15:8] : {4'h0, old[11:8]}, s[0] ? d[7:0] : old[7:0]};
    tap_merge = m[11:0];
  endfunction

  function automatic logic mapped(input logic [11:0] i);
    mapped = (i == `ADCC_IDX_TAP6) || (i == `ADCC_IDX_TAP7) ||
             (i == `ADCC_IDX_TAP8) || (i == `ADCC_IDX_TAP9) ||
             (i == `ADCC_IDX_CTRL) || (i == `ADCC_IDX_LINK) ||
             (i == `ADCC_IDX_CAL) || (i == `ADCC_IDX_STAT);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Write channel capture: address and data in either order
  wire do_write = have_aw && have_w && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      wr_addr <= 16'h0000;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        have_w <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        have_aw <= 1'b0;
        have_w <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(reg_idx(wr_addr)) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Ready is registered: a slot reopens one cycle after it frees, which
  // costs a cycle per transfer but keeps every bus output a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) s_axi_awready <= 1'b0;
      else if (!have_aw && !s_axi_bvalid) s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready) s_axi_wready <= 1'b0;
      else if (!have_w && !s_axi_bvalid) s_axi_wready <= 1'b1;
    end
  end

  wire [11:0] widx = reg_idx(wr_addr);
  wire wr_ctrl = do_write && widx == `ADCC_IDX_CTRL && wr_strb[0];

  ////////////////////////////////////////////////////////////////////////
  // Coefficient registers, reserved nibble never stored
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      taps <= '0;
    end else if (do_write) begin
      case (widx)
        `ADCC_IDX_TAP6: taps.tap6 <= tap_merge(taps.tap6, wr_data,
                                               wr_strb);
        `ADCC_IDX_TAP7: taps.tap7 <= tap_merge(taps.tap7, wr_data,
                                               wr_strb);
        `ADCC_IDX_TAP8: taps.tap8 <= tap_merge(taps.tap8, wr_data,
                                               wr_strb);
        `ADCC_IDX_TAP9: taps.tap9 <= tap_merge(taps.tap9, wr_data,
                                               wr_strb);
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software reset: a write of one holds the block in reset for 1 us
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_cnt <= 12'h000;
      soft_rst <= 1'b0;
    end else if (wr_ctrl && wr_data[`ADCC_CTRL_RESET_BIT]) begin
      reset_cnt <= 12'((`ADCC_RESET_CYCLES) - 1);
      soft_rst <= 1'b1;
    end else if (reset_cnt != 12'h000) begin
      reset_cnt <= reset_cnt - 12'h001;
    end else begin
      soft_rst <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) soft_reset_active <= 1'b0;
    else soft_reset_active <= soft_rst;
  end

  ////////////////////////////////////////////////////////////////////////
  // Control, link and calibration settings
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      cfg <= '0;
      kick <= 1'b0;
    end else if (do_write && wr_strb[0]) begin
      case (widx)
        `ADCC_IDX_CTRL: begin
          cfg.link_run <= wr_data[`ADCC_CTRL_LINK_RUN_BIT];
          cfg.cal_run <= wr_data[`ADCC_CTRL_CAL_RUN_BIT];
          cfg.overrange_detect_on <= wr_data[`ADCC_CTRL_OVR_BIT];
          kick <= wr_data[`ADCC_CTRL_KICK_BIT];
          cfg.sync_from_ts <= wr_data[`ADCC_CTRL_SYNCSRC_BIT];
        end
        `ADCC_IDX_LINK: begin
          // Link settings only change while the link is stopped
          if (!cfg.link_run) begin
            cfg.link_format_select <= wr_data[4:0];
            cfg.multiframe_length_minus_one <= wr_data[12:8];
          end
        end
        `ADCC_IDX_CAL: begin
          if (!cfg.cal_run) begin
            cfg.cal_background <= wr_data[`ADCC_CAL_BG_BIT];
            cfg.cal_offset <= wr_data[`ADCC_CAL_OFS_BIT];
          end
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Calibration kick edge and busy state
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      cal_start <= 1'b0;
      cal_busy <= 1'b0;
    end else begin
      // Kick only counts while calibration stays enabled across the write
      cal_start <= wr_ctrl && wr_data[`ADCC_CTRL_KICK_BIT] && !kick &&
                   cfg.cal_run &&
                   wr_data[`ADCC_CTRL_CAL_RUN_BIT];
      if (!cfg.cal_run) cal_busy <= 1'b0;
      else if (cal_start) cal_busy <= 1'b1;
      else if (cal_done) cal_busy <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sync source pins are asynchronous
  adcc_sync2 u_sync_se (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(single_ended_sync_input),
    .dout(sync_se)
  );
  adcc_sync2 u_sync_ts (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(timestamp_sync_input),
    .dout(sync_ts)
  );
  assign sync_sel = cfg.sync_from_ts ? sync_ts : sync_se;

  adcc_link_fsm u_link (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(cfg.link_run),
    .sync_req(sync_sel),
    .phase(phase)
  );
  always_ff @(posedge aclk) begin
    if (!aresetn) link_phase <= 2'h0;
    else link_phase <= phase;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel, one cycle after address acceptance
  logic [31:0] rd_val;
  always_comb begin
    case (reg_idx(s_axi_araddr))
      `ADCC_IDX_TAP6: rd_val = {20'h00000, taps.tap6};
      `ADCC_IDX_TAP7: rd_val = {20'h00000, taps.tap7};
      `ADCC_IDX_TAP8: rd_val = {20'h00000, taps.tap8};
      `ADCC_IDX_TAP9: rd_val = {20'h00000, taps.tap9};
      `ADCC_IDX_CTRL: rd_val = {26'h0000000, cfg.sync_from_ts, kick,
                                cfg.overrange_detect_on, cfg.cal_run,
                                cfg.link_run, soft_rst};
      `ADCC_IDX_LINK: rd_val = {19'h00000,
                                cfg.multiframe_length_minus_one,
                                3'h0, cfg.link_format_select};
      `ADCC_IDX_CAL: rd_val = {30'h00000000, cfg.cal_offset,
                               cfg.cal_background};
      `ADCC_IDX_STAT: rd_val = {27'h0000000, sync_sel, cal_busy,
                                soft_rst, phase};
      default: rd_val = 32'h00000000;
    endcase
  end
  // Read address slot reopens once the read data has been taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= mapped(reg_idx(s_axi_araddr)) ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Soft reset length in cycles, saturating so a long hold cannot wrap
  logic [7:0] soft_len;
  always_ff @(posedge aclk) begin
    if (!aresetn || !soft_rst) soft_len <= 8'h00;
    else if (soft_len != 8'hff) soft_len <= soft_len + 8'h01;
  end

  link_stop_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !cfg.link_run |-> ##2 link_phase == 2'h0)
    else $error("link not stopped");
  link_restart_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(cfg.link_run) && !soft_rst ##1 cfg.link_run |-> ##1
    link_phase == 2'h1)
    else $error("link did not restart");
  cal_stop_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !cfg.cal_run |=> !cal_busy && !cal_start)
    else $error("calibration not stopped");
  kick_edge_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    cal_start |-> $rose(kick) && cfg.cal_run)
    else $error("calibration start without kick edge");
  cal_run_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    cal_start && !soft_rst |=> cal_busy)
    else $error("calibration not enabled");
  soft_reset_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(soft_rst) |-> soft_rst [*8])
    else $error("soft reset too short");
  soft_len_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $fell(soft_rst) |-> soft_len >= 8'(`ADCC_RESET_CYCLES))
    else $error("soft reset shorter than its hold time");
  soft_clear_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $fell(soft_rst) |-> cfg == '0 && taps == '0)
    else $error("soft reset did not clear");
  link_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    cfg.link_run && !soft_rst |=> $stable(cfg.link_format_select))
    else $error("link format changed while running");
  sync_pick_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    cfg.sync_from_ts && $past(cfg.sync_from_ts) &&
    $past(cfg.sync_from_ts, 2) |->
    sync_sel == $past(timestamp_sync_input, 2))
    else $error("sync source wrong");
  cov_kick_c: cover property (@(posedge aclk) cal_start);
  cov_data_c: cover property (@(posedge aclk) link_phase == 2'h3);
  cov_reset_c: cover property (@(posedge aclk) $fell(soft_rst));
  cov_ts_c: cover property (@(posedge aclk)
    cfg.sync_from_ts && link_phase == 2'h3);
  cov_done_c: cover property (@(posedge aclk) cal_busy && cal_done);
endmodule

// >>> sim/adcc_far_end.sv
// Far-side model: receiver sync request and calibration completion
`timescale 1ns/1ps
module adcc_far_end (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] link_phase,
  input wire logic cal_start,
  input wire logic release_sync,
  input wire logic use_ts,
  output logic single_ended_sync_input,
  output logic timestamp_sync_input,
  output logic cal_done
);
  logic [3:0] cnt = 4'h0;
  ////////////////////////////////////////////////////////////////////////////
  // Only the chosen pin releases, so a wrong source select stays stuck
  assign single_ended_sync_input = release_sync & ~use_ts;
  assign timestamp_sync_input = release_sync & use_ts;
  ////////////////////////////////////////////////////////////////////////////
  // Calibration answers a fixed eight cycles after it was started
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 4'h0;
    end else if (cal_start) begin
      cnt <= 4'h8;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
  assign cal_done = (cnt == 4'h1);
endmodule

// >>> sim/adc_startup_and_fir_config_tb.sv
// Self-checking bench for the startup and equalizer tap registers
`timescale 1ns/1ps
`include "adcc_params.svh"
module adc_startup_and_fir_config_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] awaddr = 16'h0, araddr = 16'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, rel = 1'b0, use_ts = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic se_sync, ts_sync, cal_done, cal_start, srst;
  logic [1:0] bresp, rresp, rsp, link_phase;
  logic [31:0] rdata, rd;
  adcc_pkg::adcc_cfg_t cfg;
  adcc_pkg::adcc_taps_t taps;
  int failures = 0, checks = 0, seed = 9, starts = 0, exp_st = 0;
  int mdl[int];
  localparam logic [11:0] regs [7] = '{`ADCC_IDX_TAP6, `ADCC_IDX_TAP7,
    `ADCC_IDX_TAP8, `ADCC_IDX_TAP9, `ADCC_IDX_CTRL, `ADCC_IDX_LINK,
    `ADCC_IDX_CAL};
  ////////////////////////////////////////////////////////////////////////////
  initial forever #2.5 aclk = ~aclk;
  always @(posedge aclk) if (cal_start === 1'b1) starts++;
  adcc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .single_ended_sync_input(se_sync), .timestamp_sync_input(ts_sync),
    .cal_done(cal_done), .cfg(cfg), .taps(taps), .cal_start(cal_start),
    .link_phase(link_phase), .soft_reset_active(srst));
  adcc_far_end far (.aclk(aclk), .aresetn(aresetn),
    .link_phase(link_phase), .cal_start(cal_start), .release_sync(rel),
    .use_ts(use_ts), .single_ended_sync_input(se_sync),
    .timestamp_sync_input(ts_sync), .cal_done(cal_done));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [63:0] e,
                     input logic [63:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  function automatic logic [15:0] ba(input logic [11:0] i);
    return {2'b00, i, 2'b00};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Bus master: hold each channel until its own ready is sampled
  task automatic wr(input logic [11:0] i, input logic [31:0] d,
                    output logic [1:0] r);
    logic a_t, w_t;
    a_t = 1'b0;
    w_t = 1'b0;
    @(posedge aclk);
    awaddr <= ba(i);
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(a_t && w_t)) begin
      @(posedge aclk);
      if (!a_t && awready === 1'b1) begin
        a_t = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_t && wready === 1'b1) begin
        w_t = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd_bus(input logic [11:0] i, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    araddr <= ba(i);
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Compare response, update model, then compare settings outputs
  task automatic put(input logic [11:0] i, input logic [31:0] d);
    logic [1:0] r;
    logic [31:0] c, l, k;
    c = mdl[`ADCC_IDX_CTRL];
    wr(i, d, r);
    // Soft reset clears settings at the edge after the response
    if (i == `ADCC_IDX_CTRL && d[0]) @(posedge aclk);
    chk("bresp", mdl.exists(int'(i)) ? 0 : 2, r);
    if (i == `ADCC_IDX_LINK) begin
      if (!c[1]) mdl[int'(i)] = d & 32'h1f1f;
    end else if (i == `ADCC_IDX_CAL) begin
      if (!c[2]) mdl[int'(i)] = d & 32'h3;
    end else if (i == `ADCC_IDX_CTRL) begin
      mdl[int'(i)] = d & 32'h3e;
      if (d[4] && !c[4] && c[2] && d[2]) exp_st++;
      if (d[0]) foreach (mdl[j]) mdl[j] = 0;
    end else if (mdl.exists(int'(i))) begin
      mdl[int'(i)] = d & 32'hfff;
    end
    c = mdl[`ADCC_IDX_CTRL];
    l = mdl[`ADCC_IDX_LINK];
    k = mdl[`ADCC_IDX_CAL];
    chk("cfg", {c[1], c[2], c[3], c[5], k[0], k[1], l[4:0],
      l[12:8]}, cfg);
    chk("taps", {12'(mdl[regs[0]]), 12'(mdl[regs[1]]),
      12'(mdl[regs[2]]), 12'(mdl[regs[3]])}, taps);
  endtask
  task automatic get(input logic [11:0] i);
    rd_bus(i, rd, rsp);
    chk("rresp", mdl.exists(int'(i)) ? 0 : 2, rsp);
    chk("rdata", mdl.exists(int'(i)) ? mdl[int'(i)] : 0, rd);
  endtask
  task automatic wait_phase(input logic [1:0] p);
    int n;
    n = 0;
    while (link_phase !== p && n < 50) begin
      @(posedge aclk);
      n++;
    end
    chk("link_phase", p, link_phase);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    failures++;
    $display("CHECK FAILED watchdog expected done seen hang");
    final_report();
  end
  initial begin
    logic [31:0] v;
    int n;
    foreach (regs[j]) mdl[regs[j]] = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (regs[j]) get(regs[j]);
    chk("link_phase", 0, link_phase);
    put(12'h454, 32'h5a5a);
    get(12'h7ff);
    for (int j = 0; j < 4; j++) begin
      v = $random(seed);
      put(regs[j], v & 32'hfff);
      get(regs[j]);
    end
    put(`ADCC_IDX_TAP9, 32'h0800);
    put(`ADCC_IDX_CTRL, 32'h1);
    chk("soft_reset", 1, srst);
    n = 0;
    while (srst === 1'b1 && n < 400) begin
      @(posedge aclk);
      n++;
    end
    chk("soft_len", 1, n >= 185 && n <= 200);
    // Host keeps quiet after the reset trigger
    repeat (`ADCC_RESET_CYCLES) @(posedge aclk);
    foreach (regs[j]) get(regs[j]);
    put(`ADCC_IDX_CTRL, 32'h0);
    v = $random(seed);
    put(`ADCC_IDX_LINK, {19'h0, v[12:8], 3'h0, v[4:0]});
    get(`ADCC_IDX_LINK);
    put(`ADCC_IDX_CAL, 32'h1);
    put(`ADCC_IDX_CAL, 32'h2);
    put(`ADCC_IDX_CTRL, 32'h4);
    put(`ADCC_IDX_CAL, 32'h1);
    get(`ADCC_IDX_CAL);
    put(`ADCC_IDX_CTRL, 32'h0c);
    put(`ADCC_IDX_CTRL, 32'h2c);
    chk("link_phase", 0, link_phase);
    put(`ADCC_IDX_CTRL, 32'h2e);
    put(`ADCC_IDX_LINK, 32'h0);
    get(`ADCC_IDX_LINK);
    wait_phase(2'h1);
    rel <= 1'b1;
    repeat (10) @(posedge aclk);
    chk("link_phase", 1, link_phase);
    use_ts <= 1'b1;
    wait_phase(2'h3);
    rd_bus(`ADCC_IDX_STAT, rd, rsp);
    chk("stat", 32'h13, rd & 32'h13);
    rel <= 1'b0;
    wait_phase(2'h1);
    put(`ADCC_IDX_CTRL, 32'h3e);
    put(`ADCC_IDX_CTRL, 32'h3e);
    put(`ADCC_IDX_CTRL, 32'h2e);
    put(`ADCC_IDX_CTRL, 32'h3e);
    put(`ADCC_IDX_CTRL, 32'h2a);
    put(`ADCC_IDX_CTRL, 32'h3e);
    put(`ADCC_IDX_CTRL, 32'h2e);
    put(`ADCC_IDX_CTRL, 32'h3a);
    get(`ADCC_IDX_CTRL);
    repeat (12) @(posedge aclk);
    chk("cal_starts", exp_st, starts);
    final_report();
  end
endmodule
